/* verilog/loop_iso_pkg.sv */
// shared constants for the loop fault isolation sequencer
package loop_iso_pkg;
  localparam int unsigned CLK_HZ           = 40_000_000;
  // isolation timeout: two hours
  localparam int unsigned ISO_TIMEOUT_S    = 7200;
  localparam longint unsigned ISO_TIMEOUT_CYC = longint'(ISO_TIMEOUT_S) * CLK_HZ;
  // heartbeat loss detection time and per-side listening dwell, in ms
  localparam int unsigned LOSS_MS          = 3000;
  localparam int unsigned DWELL_MS         = 5000;
  localparam int unsigned LOSS_CYC         = LOSS_MS * (CLK_HZ / 1000);
  localparam int unsigned DWELL_CYC        = DWELL_MS * (CLK_HZ / 1000);
  // one millisecond tick divider
  localparam int unsigned MS_CYC           = CLK_HZ / 1000;
  localparam int unsigned TIMEOUT_MS       = ISO_TIMEOUT_S * 1000;
  localparam int unsigned CNT_W            = 32;
  localparam logic [1:0]  RELAYS_CLOSED    = 2'h0;
  localparam logic [1:0]  SYNC_RESET       = 2'h0;
  typedef enum logic [2:0] {
    ST_NORMAL,
    ST_OPEN_A,
    ST_OPEN_B,
    ST_HOLD,
    ST_DISABLED
  } iso_state_t;
endpackage

/* verilog/ms_tick.sv */
// millisecond enable pulse divider
`timescale 1ns/1ps
module ms_tick #(
  parameter int unsigned TICK_CYC = loop_iso_pkg::MS_CYC
) (
  // clock and reset
  input  wire logic mclk,
  input  wire logic reset,
  // tick output
  output logic      tick
);
  logic [15:0] count;
  logic [15:0] next_count;
  logic        next_tick;

  always_comb begin
    next_tick  = 1'b0;
    next_count = count + 16'h0001;
    if (count == 16'(TICK_CYC - 1)) begin
      next_count = 16'h0000;
      next_tick  = 1'b1;
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      count <= 16'h0000;
      tick  <= 1'b0;
    end else begin
      count <= next_count;
      tick  <= next_tick;
    end
  end
endmodule // ms_tick

/* verilog/loop_fault_isolation_sequencer.sv */
// heartbeat supervision and port isolation relay sequencer
`timescale 1ns/1ps
module loop_fault_isolation_sequencer #(
  parameter int unsigned LOSS_MS    = loop_iso_pkg::LOSS_MS,
  parameter int unsigned DWELL_MS   = loop_iso_pkg::DWELL_MS,
  parameter int unsigned TIMEOUT_MS = loop_iso_pkg::TIMEOUT_MS,
  parameter int unsigned TICK_CYC   = loop_iso_pkg::MS_CYC
) (
  // clock and reset
  input  wire logic mclk,
  input  wire logic reset,
  // heartbeat detect strobes from each loop port receiver
  input  wire logic heartbeat_a,
  input  wire logic heartbeat_b,
  // isolation relays, high opens the relay
  output logic      relay_open_a,
  output logic      relay_open_b,
  // status
  output logic      isolating,
  output logic      routine_disabled,
  output logic      status_tx_en
);
  // synchronisers
  logic [1:0] hb_pin;
  logic [1:0] hb_sync;
  logic       next_isolating;
  logic       next_routine_disabled;
  logic       next_status_tx_en;
  logic       hb_a;
  logic       hb_b;
  logic       hb_any;
  logic       tick;

  // sequencer state and counters
  loop_iso_pkg::iso_state_t state;
  loop_iso_pkg::iso_state_t next_state;
  logic [31:0] loss_cnt;
  logic [31:0] next_loss_cnt;
  logic [31:0] dwell_cnt;
  logic [31:0] next_dwell_cnt;
  logic [31:0] iso_cnt;
  logic [31:0] next_iso_cnt;
  logic [1:0]  relays;
  logic [1:0]  next_relays;

  // one enable pulse per detection time unit
  ms_tick #(
    .TICK_CYC (TICK_CYC)
  ) u_tick (
    .mclk  (mclk),
    .reset (reset),
    .tick  (tick)
  );

  assign hb_pin = {heartbeat_b, heartbeat_a};

  // two-flop synchroniser per loop port
  for (genvar p = 0; p < 2; p++) begin : g_sync
    logic [1:0] sync_ff;
    always_ff @(posedge mclk) begin
      if (reset) begin
        sync_ff <= loop_iso_pkg::SYNC_RESET;
      end else begin
        sync_ff <= {sync_ff[0], hb_pin[p]};
      end
    end
    assign hb_sync[p] = sync_ff[1];
  end

  // only the port whose relay is closed is heard
  assign hb_a   = hb_sync[0] & ~relays[0];
  assign hb_b   = hb_sync[1] & ~relays[1];
  assign hb_any = hb_a | hb_b;

  // sequencer next state
  always_comb begin
    next_state     = state;
    next_loss_cnt  = loss_cnt;
    next_dwell_cnt = dwell_cnt;
    next_iso_cnt   = iso_cnt;
    next_relays    = relays;
    unique case (state)
      loop_iso_pkg::ST_NORMAL: begin
        next_relays = loop_iso_pkg::RELAYS_CLOSED;
        if (hb_any) begin
          next_loss_cnt = 32'h0000_0000;
        end else if (tick) begin
          next_loss_cnt = loss_cnt + 32'h0000_0001;
          if (loss_cnt + 32'h0000_0001 >= LOSS_MS) begin
            next_state     = loop_iso_pkg::ST_OPEN_A;
            next_relays    = 2'h1;
            next_dwell_cnt = 32'h0000_0000;
            next_iso_cnt   = 32'h0000_0000;
          end
        end
      end
      loop_iso_pkg::ST_OPEN_A, loop_iso_pkg::ST_OPEN_B: begin
        if (hb_any) begin
          next_state    = loop_iso_pkg::ST_HOLD;
          next_loss_cnt = 32'h0000_0000;
        end else if (tick) begin
          next_iso_cnt   = iso_cnt + 32'h0000_0001;
          next_dwell_cnt = dwell_cnt + 32'h0000_0001;
          if (iso_cnt + 32'h0000_0001 >= TIMEOUT_MS) begin
            next_state  = loop_iso_pkg::ST_DISABLED;
            next_relays = loop_iso_pkg::RELAYS_CLOSED;
          end else if (dwell_cnt + 32'h0000_0001 >= DWELL_MS) begin
            next_dwell_cnt = 32'h0000_0000;
            // one-hot swap closes the old relay as the new one opens
            next_relays    = {relays[0], relays[1]};
            next_state     = (state == loop_iso_pkg::ST_OPEN_A) ?
                             loop_iso_pkg::ST_OPEN_B : loop_iso_pkg::ST_OPEN_A;
          end
        end
      end
      loop_iso_pkg::ST_HOLD: begin
        // keep the found relay state while heartbeats continue
        if (hb_any) begin
          next_loss_cnt = 32'h0000_0000;
        end else if (tick) begin
          next_loss_cnt = loss_cnt + 32'h0000_0001;
          if (loss_cnt + 32'h0000_0001 >= LOSS_MS) begin
            next_state     = loop_iso_pkg::ST_OPEN_A;
            next_relays    = 2'h1;
            next_dwell_cnt = 32'h0000_0000;
            next_iso_cnt   = 32'h0000_0000;
          end
        end
      end
      loop_iso_pkg::ST_DISABLED: begin
        next_relays = loop_iso_pkg::RELAYS_CLOSED;
        if (hb_any) begin
          next_state    = loop_iso_pkg::ST_NORMAL;
          next_loss_cnt = 32'h0000_0000;
        end
      end
      default: begin
        // illegal code: back to normal with relays closed
        next_state  = loop_iso_pkg::ST_NORMAL;
        next_relays = loop_iso_pkg::RELAYS_CLOSED;
      end
    endcase
  end

  // state register
  always_ff @(posedge mclk) begin
    if (reset) begin
      state     <= loop_iso_pkg::ST_NORMAL;
      loss_cnt  <= 32'h0000_0000;
      dwell_cnt <= 32'h0000_0000;
      iso_cnt   <= 32'h0000_0000;
      relays    <= loop_iso_pkg::RELAYS_CLOSED;
    end else begin
      state     <= next_state;
      loss_cnt  <= next_loss_cnt;
      dwell_cnt <= next_dwell_cnt;
      iso_cnt   <= next_iso_cnt;
      relays    <= next_relays;
    end
  end

  assign relay_open_a     = relays[0];
  assign relay_open_b     = relays[1];

  // status flags decoded from the next state so they line up with the relays
  always_comb begin
    next_isolating        = 1'b0;
    next_routine_disabled = 1'b0;
    next_status_tx_en     = 1'b0;
    unique case (next_state)
      loop_iso_pkg::ST_OPEN_A, loop_iso_pkg::ST_OPEN_B: begin
        next_isolating    = 1'b1;
        next_status_tx_en = 1'b0;
      end
      loop_iso_pkg::ST_DISABLED: begin
        next_routine_disabled = 1'b1;
        next_status_tx_en     = 1'b0;
      end
      loop_iso_pkg::ST_NORMAL, loop_iso_pkg::ST_HOLD: begin
        next_status_tx_en = 1'b1;
      end
      default: begin
        next_status_tx_en = 1'b0;
      end
    endcase
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      isolating        <= 1'b0;
      routine_disabled <= 1'b0;
      status_tx_en     <= 1'b1;
    end else begin
      isolating        <= next_isolating;
      routine_disabled <= next_routine_disabled;
      status_tx_en     <= next_status_tx_en;
    end
  end
endmodule // loop_fault_isolation_sequencer

/* sim/loop_iso_sva.sv */
// assertion checker for the loop isolation sequencer
`timescale 1ns/1ps
module loop_iso_sva (
  input wire logic mclk,
  input wire logic reset,
  input wire logic heartbeat_a,
  input wire logic heartbeat_b,
  input wire logic relay_open_a,
  input wire logic relay_open_b,
  input wire logic isolating,
  input wire logic routine_disabled,
  input wire logic status_tx_en
);
  default clocking @(posedge mclk); endclocking
  default disable iff (reset);
  chk_one_port_open: assert property (!(relay_open_a && relay_open_b))
    else $error("both relays open");
  chk_start_at_a: assert property ($rose(isolating) |-> relay_open_a)
    else $error("routine did not start on relay a");
  chk_iso_one_hot: assert property (isolating |-> relay_open_a ^ relay_open_b)
    else $error("no single relay open");
  chk_swap_same_edge: assert property ($fell(relay_open_a) && isolating |-> relay_open_b)
    else $error("swap not simultaneous");
  chk_disable_closes: assert property (routine_disabled |-> !relay_open_a && !relay_open_b)
    else $error("relay open while disabled");
  chk_disable_from_iso: assert property ($rose(routine_disabled) |-> $past(isolating))
    else $error("disabled outside routine");
  chk_found_held: assert property ($fell(isolating) && !routine_disabled |-> $stable(relay_open_a))
    else $error("relay moved on heartbeat found");
  chk_no_status_iso: assert property (isolating |-> !status_tx_en)
    else $error("status sent while isolating");
  cover property ($rose(relay_open_b));
  cover property ($rose(routine_disabled));
  cover property ($fell(isolating) && relay_open_a);
endmodule // loop_iso_sva
bind loop_fault_isolation_sequencer loop_iso_sva u_sva (.mclk(mclk), .reset(reset),
  .heartbeat_a(heartbeat_a), .heartbeat_b(heartbeat_b), .relay_open_a(relay_open_a),
  .relay_open_b(relay_open_b), .isolating(isolating), .routine_disabled(routine_disabled),
  .status_tx_en(status_tx_en));

/* sim/ctrl_model.sv */
// controller model sending heartbeats out of both loop ports
`timescale 1ns/1ps
module ctrl_model (
  input  wire logic mclk,
  input  wire logic send_a,
  input  wire logic send_b,
  output logic      heartbeat_a = 1'b0,
  output logic      heartbeat_b = 1'b0
);
  // one device on the loop, far inside the loop size limits
  localparam int MAX_DEVICES  = 246;
  localparam int MAX_PLAIN    = 60;
  localparam int MAX_SEGMENT  = 40;
  // offline reporting and time stamps are not modelled
  logic [3:0] phase = 4'h0;
  always_ff @(posedge mclk) begin
    phase       <= phase + 4'h1;
    heartbeat_a <= send_a && (phase == 4'h0);
    heartbeat_b <= send_b && (phase == 4'h8);
  end
endmodule // ctrl_model

/* sim/testbench.sv */
// self-checking bench for the loop isolation sequencer
`timescale 1ns/1ps
module testbench;
  logic mclk = 1'b0;
  logic reset = 1'b1;
  logic send_a = 1'b1;
  logic send_b = 1'b1;
  logic heartbeat_a, heartbeat_b, relay_open_a, relay_open_b;
  logic isolating, routine_disabled, status_tx_en;
  int   n_fail = 0;
  int   compares = 0;
  int   cyc = 0;
  ctrl_model u_ctrl (.mclk(mclk), .send_a(send_a), .send_b(send_b),
    .heartbeat_a(heartbeat_a), .heartbeat_b(heartbeat_b));
  loop_fault_isolation_sequencer #(.LOSS_MS(3), .DWELL_MS(4), .TIMEOUT_MS(20),
    .TICK_CYC(40)) u_dut (
    .mclk(mclk), .reset(reset), .heartbeat_a(heartbeat_a), .heartbeat_b(heartbeat_b),
    .relay_open_a(relay_open_a), .relay_open_b(relay_open_b), .isolating(isolating),
    .routine_disabled(routine_disabled), .status_tx_en(status_tx_en));
  initial begin
    forever #12.5 mclk = ~mclk;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #2;
  endtask
  task automatic chk(input logic got, input logic exp, input string what);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR %0t %s", $time, what);
    end
  endtask
  task automatic wait_rel(input logic a, input logic b);
    int i;
    i = 0;
    while (!(relay_open_a === a && relay_open_b === b) && i < 100000) begin
      tick(1);
      i++;
    end
    chk(relay_open_a, a, "relay a");
    chk(relay_open_b, b, "relay b");
  endtask
  task automatic close_out;
    if (n_fail == 0 && compares > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // loss, refused heartbeat on open port, swap, timeout, re-enable
  task automatic s_timeout;
    send_a = 1'b0;
    send_b = 1'b0;
    wait_rel(1'b1, 1'b0);
    send_a = 1'b1;
    tick(100);
    chk(isolating, 1'b1, "open port heartbeat taken");
    send_a = 1'b0;
    wait_rel(1'b0, 1'b1);
    tick(100);
    wait_rel(1'b0, 1'b0);
    chk(routine_disabled, 1'b1, "not disabled");
    send_a = 1'b1;
    tick(40);
    chk(routine_disabled, 1'b0, "not re-enabled");
    chk(status_tx_en, 1'b1, "no status");
  endtask
  // heartbeat found on connected port holds the relays
  task automatic s_found;
    send_a = 1'b0;
    wait_rel(1'b1, 1'b0);
    send_b = 1'b1;
    tick(40);
    chk(isolating, 1'b0, "heartbeat not found");
    tick(2000);
    wait_rel(1'b1, 1'b0);
    chk(status_tx_en, 1'b1, "no status after found");
  endtask
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      close_out();
    end
  end
  initial begin
    tick(5);
    reset = 1'b0;
    wait_rel(1'b0, 1'b0);
    s_timeout();
    s_found();
    close_out();
  end
endmodule // testbench
